//--- rtl/pdwi_ctrl.sv
// Purpose: Host controller that drives a paged 256K x 16 DRAM through its strobe pins.
// Assumes: One 10 MHz clock; every strobe edge falls on a rising clock edge, often shared with other strobes.
// Notes: Reads, early writes, page hits, hidden, row-only, column-first and self refresh.
`timescale 1ns/100ps
`default_nettype none
`include "pdwi_params.svh"

// Contract
// - Row address stable when row strobe falls.
// - Column address stable when column strobe falls.
// - Page mode keeps row open across columns.
// - Output enable high before driving data.
// - Refresh all rows within the refresh period.
// - Row-only refresh holds column strobe high.
// - Hidden refresh keeps column strobe low after read.
// - Column strobe before row means internal refresh.
// - Battery mode refresh every 125 us, short.
// - Self refresh needs both strobes low 100 us.
// - Leaving self refresh needs full burst refresh.
// - Pause 200 us then eight row cycles.
// - Column strobe leads row strobe by 10 ns.
module pdwi_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // User request and read answer
    input wire logic req_valid,
    output logic req_ready,
    input wire pdwi_pkg::pdwi_req_s req,
    output logic [`PDWI_DATA_W-1:0] rd_data,
    output logic rd_valid,
    // Mode and status
    input wire logic self_refresh_req,
    input wire logic battery_mode,
    output logic init_done,
    output logic in_self_refresh,
    // Memory pins
    output var pdwi_pkg::pdwi_strobe_s strobe,
    output logic [`PDWI_ROW_W-1:0] multiplexed_address_inputs,
    output logic [`PDWI_DATA_W-1:0] shared_data_lines_out,
    output logic shared_data_lines_oe_n,
    input wire logic [`PDWI_DATA_W-1:0] shared_data_lines_in
);

    // ======================================================================
    // Derived cycle counts
    // ======================================================================
    // Longest times round down, least times round up.
    localparam int REF_CYC = `PDWI_REFRESH_PERIOD_NS / `PDWI_ROWS / `PDWI_CLK_NS;
    localparam int BAT_CYC = `PDWI_BATTERY_PERIOD_NS / `PDWI_CLK_NS;
    localparam int INIT_CYC = (`PDWI_POWERUP_PAUSE_NS + `PDWI_CLK_NS - 1) / `PDWI_CLK_NS;
    localparam int SR_CYC = (`PDWI_SELF_REFRESH_MIN_NS + `PDWI_CLK_NS - 1) / `PDWI_CLK_NS;
    localparam int LEAD_CYC = (`PDWI_COLUMN_LEAD_NS + `PDWI_CLK_NS - 1) / `PDWI_CLK_NS;
    localparam int AW = `PDWI_ROW_W + `PDWI_COL_W;

    pdwi_pkg::pdwi_state_e state;
    pdwi_pkg::pdwi_req_s cur;
    logic [11:0] cnt;
    logic [10:0] burst_left;
    logic [3:0] init_cnt;
    logic [`PDWI_ROW_W-1:0] open_row;
    logic sr_go;
    logic [10:0] ref_cnt;
    logic [10:0] ref_lim;
    logic ref_pend;
    logic ref_take;
    logic ref_tick;
    logic page_ok;
    logic [`PDWI_DATA_W-1:0] dq_s1;
    logic [`PDWI_DATA_W-1:0] dq_s2;

    // ======================================================================
    // Handshake
    // ======================================================================
    // A page hit is offered only while the row is open and no refresh waits.
    assign page_ok = (state == pdwi_pkg::S_CAS_UP) && !ref_pend && !self_refresh_req
        && (req.addr[AW-1:`PDWI_COL_W] == open_row);
    assign req_ready = ((state == pdwi_pkg::S_IDLE) && !ref_pend && !self_refresh_req)
        || page_ok;

    // ======================================================================
    // Data pin synchroniser
    // ======================================================================
    // The data lines come from outside the clock domain, so two flops first.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dq_s1 <= 16'h0000;
            dq_s2 <= 16'h0000;
        end
        else
        begin
            dq_s1 <= shared_data_lines_in;
            dq_s2 <= dq_s1;
        end
    end

    // ======================================================================
    // Refresh timer
    // ======================================================================
    // Battery backup stretches the interval; the timer never stops, so a late
    // refresh only shortens the next gap and never lengthens it.
    assign ref_lim = battery_mode ? 11'(BAT_CYC) : 11'(REF_CYC);
    assign ref_tick = (ref_cnt >= ref_lim - 11'h001);
    assign ref_take = ((state == pdwi_pkg::S_CBR_CAS) && !sr_go)
        || ((state == pdwi_pkg::S_CBR_PRE) && (burst_left > 11'h001))
        || (state == pdwi_pkg::S_HID_PRE);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ref_cnt <= 11'h000;
            ref_pend <= 1'b0;
        end
        else
        begin
            ref_cnt <= (ref_tick || !init_done) ? 11'h000 : ref_cnt + 11'h001;
            // A tick in the cycle of a take still leaves the request standing.
            ref_pend <= (ref_tick && init_done) || (ref_pend && !ref_take);
        end
    end

    // ======================================================================
    // Sequencer and pins
    // ======================================================================
    // Every pin is a flop so the memory never sees a decode glitch.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= pdwi_pkg::S_INIT_WAIT;
            cur <= '0;
            cnt <= 12'h000;
            burst_left <= 11'h001;
            init_cnt <= 4'h0;
            open_row <= 10'h000;
            sr_go <= 1'b0;
            init_done <= 1'b0;
            in_self_refresh <= 1'b0;
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
            strobe <= 5'h1F;
            multiplexed_address_inputs <= 10'h000;
            shared_data_lines_out <= 16'h0000;
            shared_data_lines_oe_n <= 1'b1;
        end
        else
        begin
            rd_valid <= 1'b0;
            case (state)
                pdwi_pkg::S_INIT_WAIT:
                begin
                    cnt <= cnt + 12'h001;
                    if (cnt == 12'(INIT_CYC - 1))
                    begin
                        multiplexed_address_inputs <= 10'h000;
                        state <= pdwi_pkg::S_INIT_ROW;
                    end
                end
                pdwi_pkg::S_INIT_ROW:
                begin
                    strobe.ras_n <= 1'b0;
                    state <= pdwi_pkg::S_INIT_RAS;
                end
                pdwi_pkg::S_INIT_RAS:
                begin
                    strobe.ras_n <= 1'b1;
                    init_cnt <= init_cnt + 4'h1;
                    state <= pdwi_pkg::S_INIT_PRE;
                end
                pdwi_pkg::S_INIT_PRE:
                begin
                    if (init_cnt == 4'(`PDWI_INIT_ROW_CYCLES))
                    begin
                        init_done <= 1'b1;
                        state <= pdwi_pkg::S_IDLE;
                    end
                    else
                    begin
                        multiplexed_address_inputs <= 10'(init_cnt);
                        state <= pdwi_pkg::S_INIT_ROW;
                    end
                end
                pdwi_pkg::S_IDLE:
                begin
                    if (ref_pend || self_refresh_req)
                    begin
                        // Column strobe leads, so the memory counts the row itself.
                        strobe.cas_n <= 1'b0;
                        sr_go <= !ref_pend;
                        cnt <= 12'h000;
                        state <= pdwi_pkg::S_CBR_CAS;
                    end
                    else if (req_valid)
                    begin
                        cur <= req;
                        multiplexed_address_inputs <= req.addr[AW-1:`PDWI_COL_W];
                        state <= pdwi_pkg::S_RAS_SET;
                    end
                end
                pdwi_pkg::S_RAS_SET:
                begin
                    strobe.ras_n <= 1'b0;
                    open_row <= cur.addr[AW-1:`PDWI_COL_W];
                    state <= pdwi_pkg::S_ROW;
                end
                pdwi_pkg::S_ROW, pdwi_pkg::S_CAS_UP:
                begin
                    if ((state == pdwi_pkg::S_ROW) || (req_valid && page_ok))
                    begin
                        if (state == pdwi_pkg::S_CAS_UP)
                        begin
                            cur <= req;
                        end
                        // Column goes out a cycle before the strobe falls.
                        multiplexed_address_inputs <= (state == pdwi_pkg::S_ROW)
                            ? 10'(cur.addr[`PDWI_COL_W-1:0])
                            : 10'(req.addr[`PDWI_COL_W-1:0]);
                        if ((state == pdwi_pkg::S_ROW) ? cur.write : req.write)
                        begin
                            // Enables fall before the column strobe: early write.
                            strobe.oe_n <= 1'b1;
                            strobe.lower_byte_write_n <= (state == pdwi_pkg::S_ROW)
                                ? !cur.byte_en[0] : !req.byte_en[0];
                            strobe.upper_byte_write_n <= (state == pdwi_pkg::S_ROW)
                                ? !cur.byte_en[1] : !req.byte_en[1];
                            shared_data_lines_out <= (state == pdwi_pkg::S_ROW)
                                ? cur.wdata : req.wdata;
                            shared_data_lines_oe_n <= 1'b0;
                        end
                        state <= pdwi_pkg::S_COL_SET;
                    end
                    else
                    begin
                        strobe.ras_n <= 1'b1;
                        state <= pdwi_pkg::S_PRE;
                    end
                end
                pdwi_pkg::S_COL_SET:
                begin
                    strobe.cas_n <= 1'b0;
                    strobe.oe_n <= cur.write;
                    cnt <= 12'h000;
                    state <= cur.write ? pdwi_pkg::S_COL : pdwi_pkg::S_RD_WAIT;
                end
                pdwi_pkg::S_COL:
                begin
                    strobe.cas_n <= 1'b1;
                    strobe.lower_byte_write_n <= 1'b1;
                    strobe.upper_byte_write_n <= 1'b1;
                    shared_data_lines_oe_n <= 1'b1;
                    state <= pdwi_pkg::S_CAS_UP;
                end
                pdwi_pkg::S_RD_WAIT:
                begin
                    cnt <= cnt + 12'h001;
                    if (cnt == 12'(`PDWI_SYNC_LAT))
                    begin
                        rd_data <= dq_s2;
                        rd_valid <= 1'b1;
                        if (ref_pend)
                        begin
                            // Keep column strobe low so the word stays on the lines.
                            strobe.ras_n <= 1'b1;
                            state <= pdwi_pkg::S_HID_PRE;
                        end
                        else
                        begin
                            strobe.cas_n <= 1'b1;
                            strobe.oe_n <= 1'b1;
                            state <= pdwi_pkg::S_CAS_UP;
                        end
                    end
                end
                pdwi_pkg::S_HID_PRE:
                begin
                    strobe.ras_n <= 1'b0;
                    state <= pdwi_pkg::S_HID_RAS;
                end
                pdwi_pkg::S_HID_RAS:
                begin
                    strobe <= 5'h1F;
                    state <= pdwi_pkg::S_PRE;
                end
                pdwi_pkg::S_PRE:
                begin
                    state <= pdwi_pkg::S_IDLE;
                end
                pdwi_pkg::S_CBR_CAS:
                begin
                    cnt <= cnt + 12'h001;
                    if (cnt >= 12'(LEAD_CYC - 1))
                    begin
                        strobe.ras_n <= 1'b0;
                        cnt <= 12'h000;
                        in_self_refresh <= sr_go;
                        state <= sr_go ? pdwi_pkg::S_SR_HOLD : pdwi_pkg::S_CBR_RAS;
                    end
                end
                pdwi_pkg::S_CBR_RAS:
                begin
                    // One cycle low keeps battery backup well under its limit.
                    strobe.ras_n <= 1'b1;
                    state <= pdwi_pkg::S_CBR_PRE;
                end
                pdwi_pkg::S_CBR_PRE:
                begin
                    if (burst_left > 11'h001)
                    begin
                        burst_left <= burst_left - 11'h001;
                        strobe.ras_n <= 1'b0;
                        state <= pdwi_pkg::S_CBR_RAS;
                    end
                    else
                    begin
                        strobe.cas_n <= 1'b1;
                        state <= pdwi_pkg::S_PRE;
                    end
                end
                pdwi_pkg::S_SR_HOLD:
                begin
                    if (cnt != 12'hFFF)
                    begin
                        cnt <= cnt + 12'h001;
                    end
                    if ((cnt >= 12'(SR_CYC - 1)) && !self_refresh_req)
                    begin
                        strobe.ras_n <= 1'b1;
                        strobe.cas_n <= 1'b1;
                        sr_go <= 1'b0;
                        in_self_refresh <= 1'b0;
                        burst_left <= 11'(`PDWI_ROWS);
                        state <= pdwi_pkg::S_SR_EXIT;
                    end
                end
                pdwi_pkg::S_SR_EXIT:
                begin
                    strobe.cas_n <= 1'b0;
                    cnt <= 12'h000;
                    state <= pdwi_pkg::S_CBR_CAS;
                end
                default:
                begin
                    strobe <= 5'h1F;
                    state <= pdwi_pkg::S_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    logic [11:0] boot_cnt;
    logic [3:0] init_ras;
    logic [11:0] gap_cnt;
    logic gap_mode;

    // Helper counters that only the checks read.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            boot_cnt <= 12'h000;
            init_ras <= 4'h0;
            gap_cnt <= 12'h000;
            gap_mode <= 1'b0;
        end
        else
        begin
            gap_mode <= battery_mode;
            if (boot_cnt != 12'hFFF)
            begin
                boot_cnt <= boot_cnt + 12'h001;
            end
            if (!init_done && !strobe.ras_n && (state == pdwi_pkg::S_INIT_RAS)
                && (init_ras != 4'hF))
            begin
                init_ras <= init_ras + 4'h1;
            end
            // A change of refresh rate restarts the gap, as the old interval no longer applies.
            gap_cnt <= (ref_take || !init_done || in_self_refresh
                || (gap_mode != battery_mode)) ? 12'h000 : gap_cnt + 12'h001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    row_addr_stable_a: assert property (
        $fell(strobe.ras_n) |-> $stable(multiplexed_address_inputs))
        else $error("Row address moved as row strobe fell.");
    col_addr_stable_a: assert property (
        $fell(strobe.cas_n) && !strobe.ras_n |-> $stable(multiplexed_address_inputs))
        else $error("Column address moved as column strobe fell.");
    drive_oe_high_a: assert property (
        !shared_data_lines_oe_n |-> strobe.oe_n && (strobe.cas_n || $past(strobe.cas_n)))
        else $error("Data driven while memory outputs may be on.");
    column_lead_a: assert property (
        $fell(strobe.ras_n) && !strobe.cas_n |-> $past(strobe.cas_n, 1) == 1'b0)
        else $error("Column strobe did not lead row strobe.");
    init_pause_a: assert property (
        $fell(strobe.ras_n) |-> boot_cnt > 12'(INIT_CYC))
        else $error("Row strobe before the power-up pause ended.");
    init_eight_a: assert property (
        $rose(init_done) |-> init_ras == 4'(`PDWI_INIT_ROW_CYCLES) && strobe.cas_n)
        else $error("Wrong number of start-up row cycles.");
    refresh_gap_a: assert property (
        gap_cnt <= 12'(ref_lim) + 12'h018)
        else $error("Refresh interval overrun.");
    short_refresh_a: assert property (
        (state == pdwi_pkg::S_CBR_RAS) |-> !strobe.ras_n ##1 strobe.ras_n)
        else $error("Refresh row strobe held too long.");
    sr_hold_a: assert property (
        $rose(strobe.ras_n) && $past(state == pdwi_pkg::S_SR_HOLD)
        |-> $past(cnt) >= 12'(SR_CYC - 1))
        else $error("Self refresh left too early.");
    sr_burst_a: assert property (
        (state == pdwi_pkg::S_SR_EXIT) |-> burst_left == 11'(`PDWI_ROWS) && !req_ready)
        else $error("No full burst after self refresh.");
    burst_cas_low_a: assert property (
        (state == pdwi_pkg::S_CBR_RAS) && (burst_left > 11'h001) |=> !strobe.cas_n [*2])
        else $error("Column strobe rose inside a refresh burst.");

    read_done_c: cover property (rd_valid && !cur.write);
    page_hit_c: cover property (req_valid && page_ok);
    hidden_ref_c: cover property (state == pdwi_pkg::S_HID_RAS);
    sr_exit_c: cover property (state == pdwi_pkg::S_SR_EXIT);

endmodule

`default_nettype wire

//--- rtl/pdwi_params.svh
// Purpose: Timing figures and field layout for the paged DRAM word interface controller.
// Assumes: A 10 MHz controller clock; times are in nanoseconds.
// Notes: Counts of cycles are derived from these figures inside the controller.
`ifndef PDWI_PARAMS_SVH
`define PDWI_PARAMS_SVH

// ==========================================================================
// Clock and field layout
// ==========================================================================
`define PDWI_CLK_NS 100
`define PDWI_ROW_W 10
`define PDWI_COL_W 8
`define PDWI_DATA_W 16
`define PDWI_ROWS 1024

// ==========================================================================
// Times
// ==========================================================================
`define PDWI_REFRESH_PERIOD_NS 16000000
`define PDWI_BATTERY_PERIOD_NS 125000
`define PDWI_POWERUP_PAUSE_NS 200000
`define PDWI_SELF_REFRESH_MIN_NS 100000
`define PDWI_COLUMN_LEAD_NS 10
`define PDWI_INIT_ROW_CYCLES 8
`define PDWI_SYNC_LAT 2 // Read word leaves the second flop two cycles after the column fall.

`endif

//--- rtl/pdwi_pkg.sv
// Purpose: Types shared by the paged DRAM word interface controller and its bench.
// Assumes: pdwi_params.svh gives the field widths.
// Notes: Only types live here; every number is a macro of the header.
`include "pdwi_params.svh"

package pdwi_pkg;

    // ======================================================================
    // Request from the user side
    // ======================================================================
    typedef struct packed {
        logic write;
        logic [1:0] byte_en;
        logic [`PDWI_ROW_W+`PDWI_COL_W-1:0] addr;
        logic [`PDWI_DATA_W-1:0] wdata;
    } pdwi_req_s;

    // ======================================================================
    // Active-low strobes toward the memory
    // ======================================================================
    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic oe_n;
        logic upper_byte_write_n;
        logic lower_byte_write_n;
    } pdwi_strobe_s;

    typedef enum logic [4:0] {
        S_INIT_WAIT, S_INIT_ROW, S_INIT_RAS, S_INIT_PRE, S_IDLE, S_RAS_SET, S_ROW,
        S_COL_SET, S_COL, S_RD_WAIT, S_CAS_UP, S_PRE, S_HID_PRE, S_HID_RAS,
        S_CBR_CAS, S_CBR_RAS, S_CBR_PRE, S_SR_HOLD, S_SR_EXIT
    } pdwi_state_e;

endpackage

//--- verif/paged_dram_word_interface_test.sv
// Purpose: Self-checking bench for the paged DRAM word interface controller.
// Assumes: The memory model stands on the far side of the strobe pins.
// Notes: Requests are held until the ready seen at a falling edge is taken.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Bench
// ==========================================================================
module paged_dram_word_interface_test;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    logic self_refresh_req = 1'b0;
    logic battery_mode = 1'b0;
    pdwi_pkg::pdwi_req_s req = '0;
    logic req_ready, rd_valid, init_done, in_self_refresh, dq_oe_n;
    logic [15:0] rd_data, dq_out, dq;
    logic [9:0] addr;
    pdwi_pkg::pdwi_strobe_s strobe;
    int errors = 0;
    int total_checks = 0;
    int r0;
    always #50 clk = ~clk;
    pdwi_ctrl dut (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rd_data(rd_data), .rd_valid(rd_valid), .self_refresh_req(self_refresh_req),
        .battery_mode(battery_mode), .init_done(init_done), .in_self_refresh(in_self_refresh),
        .strobe(strobe), .multiplexed_address_inputs(addr), .shared_data_lines_out(dq_out),
        .shared_data_lines_oe_n(dq_oe_n), .shared_data_lines_in(dq));
    pdwi_dram_model mdl (.strobe(strobe), .addr(addr), .dq_ctl(dq_out),
        .dq_ctl_oe_n(dq_oe_n), .dq(dq));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // A bounded wait, so a stuck handshake shows up as a mismatch and not a hang.
    task automatic wait_on(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++)
            @(negedge clk);
        chk("handshake", 16'(s === v), 16'h0001);
    endtask
    task automatic xfer(input logic w, input logic [1:0] be, input logic [17:0] a,
        input logic [15:0] d);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{w, be, a, d};
        @(negedge clk);
        wait_on(req_ready, 1'b1, 5000);
        @(posedge clk);
        req_valid <= 1'b0;
    endtask
    task automatic rd(input logic [17:0] a, input logic [15:0] exp);
        xfer(1'b0, 2'b11, a, 16'h0000);
        @(negedge clk);
        wait_on(rd_valid, 1'b1, 12);
        chk("rd_data", rd_data, exp);
    endtask
    task automatic t_init;
        repeat (1990) @(negedge clk);
        chk("pause", 16'(mdl.ras_falls), 16'h0000);
        wait_on(init_done, 1'b1, 200);
        chk("init_rows", 16'(mdl.ras_falls >= 8), 16'h0001);
        $display("t_init done");
    endtask
    task automatic t_words;
        xfer(1'b1, 2'b11, 18'h23456, 16'hA5C3);
        xfer(1'b1, 2'b11, 18'h33456, 16'h5A3C);
        rd(18'h23456, 16'hA5C3);
        rd(18'h33456, 16'h5A3C);
        xfer(1'b1, 2'b01, 18'h23456, 16'hABCD);
        rd(18'h23456, 16'hA5CD);
        xfer(1'b1, 2'b10, 18'h23456, 16'hEF00);
        xfer(1'b1, 2'b00, 18'h23456, 16'hFFFF);
        rd(18'h23456, 16'hEFCD);
        xfer(1'b1, 2'b11, 18'h3FF00, 16'h0F0F);
        xfer(1'b1, 2'b11, 18'h3FFFF, 16'hF0F0);
        rd(18'h3FF00, 16'h0F0F);
        rd(18'h3FFFF, 16'hF0F0);
        $display("t_words done");
    endtask
    // Periodic refresh, first at the normal rate and then stretched for battery backup.
    task automatic t_refresh;
        r0 = mdl.ref_total;
        repeat (400) @(negedge clk);
        chk("refresh", 16'(mdl.ref_total - r0 >= 2), 16'h0001);
        @(posedge clk);
        battery_mode <= 1'b1;
        r0 = mdl.ref_total;
        repeat (1300) @(negedge clk);
        chk("battery", 16'(mdl.ref_total - r0 inside {[1:2]}), 16'h0001);
        @(posedge clk);
        battery_mode <= 1'b0;
        $display("t_refresh done");
    endtask
    task automatic t_self;
        @(posedge clk);
        self_refresh_req <= 1'b1;
        wait_on(in_self_refresh, 1'b1, 300);
        repeat (1100) @(negedge clk);
        chk("self_hold", 16'(in_self_refresh), 16'h0001);
        @(posedge clk);
        self_refresh_req <= 1'b0;
        r0 = mdl.ref_total;
        rd(18'h3FFFF, 16'hF0F0);
        chk("burst", 16'(mdl.ref_total - r0 >= 1024), 16'h0001);
        $display("t_self done");
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        t_init();
        t_words();
        t_refresh();
        t_self();
        test_done();
    end
    // The tests need about 7000 cycles; 30000 leaves a wide margin.
    initial
    begin
        #3000000;
        errors++;
        test_done();
    end
endmodule
`default_nettype wire

//--- verif/pdwi_dram_model.sv
// Purpose: Behavioural paged DRAM word memory that answers the controller's strobes.
// Assumes: Strobes are active low; the controller owns the data lines while its enable is low.
// Notes: Self refresh is not timed inside; only the internal refresh counter moves.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Memory model
// ==========================================================================
module pdwi_dram_model (
    // Strobes and address
    input wire pdwi_pkg::pdwi_strobe_s strobe,
    input wire logic [9:0] addr,
    // Data lines
    input wire logic [15:0] dq_ctl,
    input wire logic dq_ctl_oe_n,
    output logic [15:0] dq
);
    logic [15:0] mem [logic [17:0]];
    logic [9:0] row = 10'h000;
    logic [17:0] k = 18'h00000;
    logic [9:0] ref_cnt = 10'h000;
    logic early = 1'b0;
    logic on = 1'b0;
    logic [15:0] float_v = 16'h5A5A;
    int ras_falls = 0;
    int ref_total = 0;
    // A row fall with the column strobe already low refreshes an internal row.
    always @(negedge strobe.ras_n)
    begin
        ras_falls++;
        if (!strobe.cas_n)
        begin
            ref_cnt = ref_cnt + 10'h001;
            ref_total++;
        end
        else
            row = addr;
    end
    // The column fall latches the column and stores the enabled bytes of an early write.
    always @(negedge strobe.cas_n)
    begin
        if (!strobe.ras_n)
        begin
            k = {row, addr[7:0]};
            early = !strobe.lower_byte_write_n || !strobe.upper_byte_write_n;
            if (early && !mem.exists(k))
                mem[k] = 16'h0000;
            if (!strobe.lower_byte_write_n)
                mem[k][7:0] = dq_ctl[7:0];
            if (!strobe.upper_byte_write_n)
                mem[k][15:8] = dq_ctl[15:8];
        end
    end
    always @(posedge strobe.cas_n)
        early = 1'b0;
    // Outputs switch on with all three strobes low and hold until enable or column rises.
    always @*
    begin
        if (strobe.oe_n || strobe.cas_n)
            on = 1'b0;
        else if (!strobe.ras_n && !early)
            on = 1'b1;
    end
    // Released lines toggle so that a stale capture can never look right.
    always @(strobe)
        float_v = ~float_v;
    always @*
    begin
        if (!dq_ctl_oe_n)
            dq = dq_ctl;
        else if (on)
            dq = mem.exists(k) ? mem[k] : 16'h0000;
        else
            dq = float_v;
    end
endmodule
`default_nettype wire
